// [nsc_consts.svh]
// Offsets, field positions, command codes, reset values and timing counts of the NAND host.
`ifndef NSC_CONSTS_SVH
`define NSC_CONSTS_SVH
// Register byte offsets on the Avalon-MM slave.
`define NSC_REG_CMD 5'h00
`define NSC_REG_STAT 5'h04
`define NSC_REG_ID0 5'h08
`define NSC_REG_ID1 5'h0c
`define NSC_REG_WP 5'h10
`define NSC_REG_PAGE 5'h14
`define NSC_REG_DATA 5'h18
// Status register field positions.
`define NSC_ST_SEQ_BUSY 0
`define NSC_ST_DEV_READY 1
`define NSC_ST_REFUSED 2
`define NSC_ST_SUSPECT 3
`define NSC_ST_CUR_VALID 4
`define NSC_ST_PREV_VALID 5
`define NSC_ST_DUAL 6
`define NSC_ST_STATUS_MODE 7
// Status byte bit positions as the device drives them.
`define NSC_SB_PF_CUR 0
`define NSC_SB_PF_PREV 1
`define NSC_SB_BUF_READY 5
`define NSC_SB_CACHE_READY 6
`define NSC_SB_UNPROT 7
// Page-order register fields.
`define NSC_PG_PAGE_W 6
`define NSC_PG_BLOCK_W 11
// Command codes the host may send.
`define NSC_C_READ 8'h00
`define NSC_C_READ2 8'h05
`define NSC_C_PROG 8'h10
`define NSC_C_MPROG 8'h11
`define NSC_C_CPROG 8'h15
`define NSC_C_READGO 8'h30
`define NSC_C_CREAD 8'h31
`define NSC_C_CREADEND 8'h3f
`define NSC_C_ERASE 8'h60
`define NSC_C_STATUS 8'h70
`define NSC_C_MSTATUS 8'h71
`define NSC_C_SERIN 8'h80
`define NSC_C_SERIN2 8'h81
`define NSC_C_COLCHG 8'h85
`define NSC_C_COPY 8'h8c
`define NSC_C_ID 8'h90
`define NSC_C_ERASEGO 8'hd0
`define NSC_C_COLOUT 8'he0
`define NSC_C_RESET 8'hff
// Reset values.
`define NSC_RST_WP 1'b0
`define NSC_RST_BYTE 8'h00
// Each strobe phase is held this long; reads need room for the input synchroniser.
`define NSC_CLK_MHZ 100
`define NSC_PHASE_NS 60
`define NSC_PHASE_CYC ((`NSC_PHASE_NS * `NSC_CLK_MHZ + 999) / 1000)
`define NSC_ID_BYTES 5
`endif

// [nsc_pkg.sv]
// Types shared by the NAND host controller.
package nsc_pkg;
    // Strobe sequencer states, Gray coded along the write-then-read path.
    typedef enum logic [2:0] {
        NSC_IDLE = 3'b000,
        NSC_WR_LO = 3'b001,
        NSC_WR_HI = 3'b011,
        NSC_RD_LO = 3'b010,
        NSC_RD_HI = 3'b110
    } nsc_seq_e;
    // Operations software may order through the command register.
    typedef enum logic [3:0] {
        NSC_OP_STATUS = 4'h0,
        NSC_OP_MSTATUS = 4'h1,
        NSC_OP_RESET = 4'h2,
        NSC_OP_READID = 4'h3,
        NSC_OP_RESUME = 4'h4,
        NSC_OP_RAW = 4'h5,
        NSC_OP_ADDR = 4'h6,
        NSC_OP_RDBYTE = 4'h7,
        NSC_OP_WRDATA = 4'h8
    } nsc_op_e;
    // Where a captured byte goes.
    typedef enum logic [1:0] {
        NSC_DST_STATUS = 2'h0,
        NSC_DST_ID = 2'h1,
        NSC_DST_DATA = 2'h2
    } nsc_dst_e;
endpackage

// [nsc_sync.sv]
// Three-stage input synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/1ps
module nsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Asynchronous input and its clean copy.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1; // Read only by s2, never by logic.
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // The chain itself plus the agreement filter on the last two stages.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            dout <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            // Per bit, a change counts only once both late stages hold it.
            dout <= (s2 & s3) | (dout & (s2 | s3));
        end
    end
endmodule

// [nsc_host.sv]
// NAND host controller: Avalon-MM register front end driving a NAND device's pins.
`timescale 1ns/1ps
`include "nsc_consts.svh"
module nsc_host (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // NAND device pins.
    output logic ceN,
    output logic cle,
    output logic ale,
    output logic weN,
    output logic readStrobeN,
    output logic wpN,
    output logic [7:0] dqOut,
    output logic dqOe,
    input wire logic [7:0] dqIn,
    input wire logic readyBusyN
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam int PHASE_CYC = `NSC_PHASE_CYC;
    logic devReady; // Synchronised ready level.
    logic [7:0] dqSync; // Synchronised data port.
    nsc_pkg::nsc_seq_e seq; // Strobe sequencer state.
    logic [3:0] phaseCnt; // Divider producing the phase tick.
    logic phaseTick; // One-cycle enable at each phase end.
    logic [7:0] wrVal [2]; // Bytes queued for writing.
    logic wrCle [2];
    logic wrAle [2];
    logic wrIdx;
    logic wrLast;
    logic [2:0] rdLeft;
    logic [2:0] rdIdx;
    nsc_pkg::nsc_dst_e rdDst;
    logic [7:0] idByte [`NSC_ID_BYTES];
    logic [7:0] statusByte; // Last status byte read.
    logic [7:0] dataByte; // Last plain data byte read.
    logic [7:0] prevCmd; // Command before the latest NSC_C_STATUS command.
    logic [7:0] lastCmd;
    logic dualReady; // Ready bits may legitimately differ.
    logic progErase; // Last operation was program or erase.
    logic dataInOpen, cacheProg, statusMode;
    logic refused, suspect;
    logic [`NSC_PG_PAGE_W-1:0] pgPage, lastPage;
    logic [`NSC_PG_BLOCK_W-1:0] pgBlock, lastBlock;
    logic lastValid;

    nsc_sync #(.W(1), .INIT(1'b0)) uRb (
        .clk_sys(clk_sys), .resetn(resetn), .din(readyBusyN), .dout(devReady));
    nsc_sync #(.W(8), .INIT(8'h00)) uDq (
        .clk_sys(clk_sys), .resetn(resetn), .din(dqIn), .dout(dqSync));

    ////////////////////////////////////////////////////////////////////////////////
    // Command decoding and the host-side guards.
    function automatic logic isDefined(input logic [7:0] c);
        case (c)
            `NSC_C_READ, `NSC_C_READ2, `NSC_C_PROG, `NSC_C_MPROG, `NSC_C_CPROG,
            `NSC_C_READGO, `NSC_C_CREAD, `NSC_C_CREADEND, `NSC_C_ERASE, `NSC_C_STATUS,
            `NSC_C_MSTATUS, `NSC_C_SERIN, `NSC_C_SERIN2, `NSC_C_COLCHG, `NSC_C_COPY,
            `NSC_C_ID, `NSC_C_ERASEGO, `NSC_C_COLOUT, `NSC_C_RESET: isDefined = 1'b1;
            default: isDefined = 1'b0;
        endcase
    endfunction

    logic wrAccess, opReq, hasCmd, refuse, accept;
    logic [3:0] op;
    logic [7:0] arg, code;
    assign wrAccess = avs_write && !avs_waitrequest;
    assign opReq = wrAccess && (avs_address == `NSC_REG_CMD);
    assign op = avs_writedata[3:0];
    assign arg = avs_writedata[15:8];

    // Pick the command code each operation sends, if any.
    always_comb begin
        hasCmd = 1'b1;
        case (op)
            nsc_pkg::NSC_OP_STATUS: code = `NSC_C_STATUS;
            nsc_pkg::NSC_OP_MSTATUS: code = `NSC_C_MSTATUS;
            nsc_pkg::NSC_OP_RESET: code = `NSC_C_RESET;
            nsc_pkg::NSC_OP_READID: code = `NSC_C_ID;
            nsc_pkg::NSC_OP_RESUME: code = `NSC_C_READ;
            nsc_pkg::NSC_OP_RAW: code = arg;
            default: begin
                code = 8'h00;
                hasCmd = 1'b0;
            end
        endcase
    end

    // An order is refused rather than ever putting a forbidden code on the pins.
    always_comb begin
        refuse = (seq != nsc_pkg::NSC_IDLE) || (op > nsc_pkg::NSC_OP_WRDATA);
        if (hasCmd) begin
            if (!isDefined(code))
                refuse = 1'b1;
            if (!devReady && code != `NSC_C_STATUS && code != `NSC_C_MSTATUS
                    && code != `NSC_C_RESET)
                refuse = 1'b1;
            if (dataInOpen && code != `NSC_C_COLCHG && code != `NSC_C_PROG
                    && code != `NSC_C_MPROG && code != `NSC_C_CPROG && code != `NSC_C_RESET)
                refuse = 1'b1;
            if (code == `NSC_C_SERIN && lastValid && pgBlock == lastBlock
                    && pgPage <= lastPage)
                refuse = 1'b1;
        end
        if (op == nsc_pkg::NSC_OP_RESUME && !statusMode)
            refuse = 1'b1;
    end
    assign accept = opReq && !refuse;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase divider: runs only while the sequencer is moving the pins.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            phaseCnt <= 4'h0;
        else if (seq == nsc_pkg::NSC_IDLE || phaseTick)
            phaseCnt <= 4'h0;
        else
            phaseCnt <= phaseCnt + 4'h1;
    end
    assign phaseTick = (phaseCnt == 4'(PHASE_CYC - 1));
    assign wrLast = (wrIdx == 1'b1) || !wrCle[1] && !wrAle[1];

    // Strobe sequencer: write bytes on the write strobe, then read bytes on the read strobe.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seq <= nsc_pkg::NSC_IDLE;
            ceN <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            weN <= 1'b1;
            readStrobeN <= 1'b1;
            dqOut <= `NSC_RST_BYTE;
            dqOe <= 1'b0;
            wrIdx <= 1'b0;
            rdIdx <= 3'h0;
        end else begin
            case (seq)
                nsc_pkg::NSC_IDLE: begin
                    wrIdx <= 1'b0;
                    rdIdx <= 3'h0;
                    if (accept) begin
                        ceN <= 1'b0;
                        if (op == nsc_pkg::NSC_OP_RDBYTE) begin
                            seq <= nsc_pkg::NSC_RD_LO;
                            readStrobeN <= 1'b0;
                        end else begin
                            seq <= nsc_pkg::NSC_WR_LO;
                            weN <= 1'b0;
                            dqOe <= 1'b1;
                            dqOut <= hasCmd ? code : arg;
                            cle <= hasCmd;
                            ale <= (op == nsc_pkg::NSC_OP_ADDR);
                        end
                    end
                end
                nsc_pkg::NSC_WR_LO: if (phaseTick) begin
                    // Rising write strobe latches the byte.
                    seq <= nsc_pkg::NSC_WR_HI;
                    weN <= 1'b1;
                end
                nsc_pkg::NSC_WR_HI: if (phaseTick) begin
                    if (!wrLast) begin
                        seq <= nsc_pkg::NSC_WR_LO;
                        wrIdx <= 1'b1;
                        weN <= 1'b0;
                        dqOut <= wrVal[1];
                        cle <= wrCle[1];
                        ale <= wrAle[1];
                    end else begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        dqOe <= 1'b0;
                        if (rdLeft != 3'h0) begin
                            seq <= nsc_pkg::NSC_RD_LO;
                            readStrobeN <= 1'b0;
                        end else begin
                            seq <= nsc_pkg::NSC_IDLE;
                            ceN <= 1'b1;
                        end
                    end
                end
                nsc_pkg::NSC_RD_LO: if (phaseTick) begin
                    seq <= nsc_pkg::NSC_RD_HI;
                    readStrobeN <= 1'b1;
                end
                nsc_pkg::NSC_RD_HI: if (phaseTick) begin
                    rdIdx <= rdIdx + 3'h1;
                    if (rdIdx + 3'h1 < rdLeft) begin
                        seq <= nsc_pkg::NSC_RD_LO;
                        readStrobeN <= 1'b0;
                    end else begin
                        seq <= nsc_pkg::NSC_IDLE;
                        ceN <= 1'b1;
                    end
                end
                default: seq <= nsc_pkg::NSC_IDLE;
            endcase
        end
    end

    // Queue for the second written byte and the read plan of an accepted order.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrVal[0] <= 8'h00;
            wrVal[1] <= 8'h00;
            wrCle[0] <= 1'b0;
            wrCle[1] <= 1'b0;
            wrAle[0] <= 1'b0;
            wrAle[1] <= 1'b0;
            rdLeft <= 3'h0;
            rdDst <= nsc_pkg::NSC_DST_DATA;
        end else if (accept) begin
            wrVal[0] <= hasCmd ? code : arg;
            wrCle[0] <= hasCmd;
            wrAle[0] <= (op == nsc_pkg::NSC_OP_ADDR);
            // Identification needs one address byte of zero after its command.
            wrVal[1] <= 8'h00;
            wrCle[1] <= 1'b0;
            wrAle[1] <= (op == nsc_pkg::NSC_OP_READID);
            case (op)
                nsc_pkg::NSC_OP_STATUS, nsc_pkg::NSC_OP_MSTATUS: begin
                    rdLeft <= 3'h1;
                    rdDst <= nsc_pkg::NSC_DST_STATUS;
                end
                nsc_pkg::NSC_OP_READID: begin
                    rdLeft <= 3'(`NSC_ID_BYTES);
                    rdDst <= nsc_pkg::NSC_DST_ID;
                end
                nsc_pkg::NSC_OP_RDBYTE: begin
                    rdLeft <= 3'h1;
                    rdDst <= statusMode ? nsc_pkg::NSC_DST_STATUS : nsc_pkg::NSC_DST_DATA;
                end
                default: rdLeft <= 3'h0;
            endcase
        end
    end

    // Capture a read byte just before the read strobe rises.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            statusByte <= 8'h00;
            dataByte <= 8'h00;
            for (int i = 0; i < `NSC_ID_BYTES; i++)
                idByte[i] <= 8'h00;
        end else if (seq == nsc_pkg::NSC_RD_LO && phaseTick) begin
            case (rdDst)
                nsc_pkg::NSC_DST_STATUS: statusByte <= dqSync;
                nsc_pkg::NSC_DST_ID: idByte[rdIdx] <= dqSync;
                default: dataByte <= dqSync;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol tracking: what the device is doing, as seen from the commands sent.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dataInOpen <= 1'b0;
            cacheProg <= 1'b0;
            statusMode <= 1'b0;
            lastCmd <= 8'h00;
            prevCmd <= 8'h00;
            progErase <= 1'b0;
            lastValid <= 1'b0;
            lastPage <= '0;
            lastBlock <= '0;
        end else if (accept && hasCmd) begin
            lastCmd <= code;
            if (code == `NSC_C_STATUS)
                prevCmd <= lastCmd;
            case (code)
                // reset ends pending input, cache programming and status mode
                `NSC_C_RESET: begin
                    dataInOpen <= 1'b0;
                    cacheProg <= 1'b0;
                    statusMode <= 1'b0;
                    progErase <= 1'b0;
                end
                `NSC_C_SERIN: begin
                    dataInOpen <= 1'b1;
                    lastValid <= 1'b1;
                    lastPage <= pgPage;
                    lastBlock <= pgBlock;
                end
                `NSC_C_PROG, `NSC_C_MPROG, `NSC_C_CPROG, `NSC_C_ERASEGO: begin
                    dataInOpen <= 1'b0;
                    progErase <= 1'b1;
                    cacheProg <= (code == `NSC_C_CPROG);
                    if (code == `NSC_C_ERASEGO)
                        lastValid <= 1'b0;
                end
                `NSC_C_COPY: cacheProg <= 1'b1;
                // A read start makes the pass/fail bits meaningless again.
                `NSC_C_READGO, `NSC_C_CREAD: progErase <= 1'b0;
                `NSC_C_STATUS, `NSC_C_MSTATUS: statusMode <= 1'b1;
                `NSC_C_READ: statusMode <= 1'b0;
                default: ;
            endcase
        end else if (wrAccess && avs_address == `NSC_REG_WP && !avs_writedata[0]) begin
            dataInOpen <= 1'b0;
            cacheProg <= 1'b0;
        end
    end

    // ready bits may differ only here
    assign dualReady = (prevCmd == `NSC_C_CPROG) || (prevCmd == `NSC_C_CREAD);

    // Sticky flags; a new event in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            refused <= 1'b0;
            suspect <= 1'b0;
        end else begin
            if (opReq && refuse)
                refused <= 1'b1;
            else if (wrAccess && avs_address == `NSC_REG_STAT && avs_writedata[`NSC_ST_REFUSED])
                refused <= 1'b0;
            if ((accept && hasCmd && code == `NSC_C_RESET && cacheProg)
                    || (wrAccess && avs_address == `NSC_REG_WP && !avs_writedata[0]
                        && cacheProg))
                suspect <= 1'b1;
            else if (wrAccess && avs_address == `NSC_REG_STAT && avs_writedata[`NSC_ST_SUSPECT])
                suspect <= 1'b0;
        end
    end

    // Write-protect level and page-order registers.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wpN <= `NSC_RST_WP;
            pgPage <= '0;
            pgBlock <= '0;
        end else if (wrAccess && avs_address == `NSC_REG_WP) begin
            wpN <= avs_writedata[0];
        end else if (wrAccess && avs_address == `NSC_REG_PAGE) begin
            pgPage <= avs_writedata[`NSC_PG_PAGE_W-1:0];
            pgBlock <= avs_writedata[`NSC_PG_PAGE_W +: `NSC_PG_BLOCK_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status interpretation of the last status byte.
    logic statusBitPassFailCurrent, statusBitPassFailPrevious;
    logic statusBitBufferReady, statusBitCacheReady, statusBitUnprotected;
    logic curValid, prevValid;
    assign statusBitPassFailCurrent = statusByte[`NSC_SB_PF_CUR];
    assign statusBitPassFailPrevious = statusByte[`NSC_SB_PF_PREV];
    assign statusBitBufferReady = statusByte[`NSC_SB_BUF_READY];
    assign statusBitCacheReady = statusByte[`NSC_SB_CACHE_READY];
    assign statusBitUnprotected = statusByte[`NSC_SB_UNPROT];
    assign curValid = progErase && statusBitBufferReady;
    assign prevValid = progErase && cacheProg && statusBitCacheReady;

    // Avalon slave: one wait cycle, read data stands at the edge waitrequest is low.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `NSC_REG_CMD: avs_readdata <= {16'h0000, lastCmd, 8'h00};
                    `NSC_REG_STAT: avs_readdata <= {statusBitUnprotected,
                        statusBitCacheReady, statusBitBufferReady, 3'h0,
                        statusBitPassFailPrevious, statusBitPassFailCurrent,
                        16'h0000, statusMode, dualReady, prevValid, curValid,
                        suspect, refused, devReady, seq != nsc_pkg::NSC_IDLE};
                    `NSC_REG_ID0: avs_readdata <= {idByte[3], idByte[2], idByte[1], idByte[0]};
                    `NSC_REG_ID1: avs_readdata <= {17'h00000, idByte[4][3:2], idByte[3][6],
                        idByte[3][5:4], idByte[3][1:0], idByte[4]};
                    `NSC_REG_WP: avs_readdata <= {30'h0000_0000, statusBitUnprotected, wpN};
                    `NSC_REG_PAGE: avs_readdata <= {15'h0000, pgBlock, pgPage};
                    `NSC_REG_DATA: avs_readdata <= {24'h000000, dataByte};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// [nsc_host_properties.sv]
// Bus and NAND pin timing checks of the host controller.
`timescale 1ns/1ps
module nsc_host_properties (
    // Host ports under watch.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic readStrobeN,
    input wire logic wpN,
    input wire logic [7:0] dqOut,
    input wire logic dqOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ack_one_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late ack");
    strobe_excl_a: assert property (!(!weN && !readStrobeN)) else $error("strobe clash");
    we_phase_a: assert property ($fell(weN) |-> !weN [*6] ##1 weN) else $error("bad wr");
    rd_phase_a: assert property (
        $fell(readStrobeN) |-> !readStrobeN [*6] ##1 readStrobeN) else $error("bad rd");
    ce_frame_a: assert property (!weN || !readStrobeN |-> !ceN) else $error("no ce");
    turn_a: assert property (!readStrobeN |-> !dqOe && !cle && !ale) else $error("clash");
    stat_rd_a: assert property (
        $rose(weN) && cle && dqOut == 8'h70 |-> ##6 $fell(readStrobeN)) else $error("no read");
    wp_pin_a: assert property (
        avs_write && !avs_waitrequest && avs_address == 5'h10 |=> wpN == $past(avs_writedata[0]))
        else $error("wp stale");
endmodule
bind nsc_host nsc_host_properties chk (.*);

// [nsc_nand_model.sv]
// Behavioural NAND device answering status and feature reads.
`timescale 1ns/1ps
module nsc_nand_model (
    // Pins from the host, busy request from the bench.
    input wire logic ceN,
    input wire logic cle,
    input wire logic weN,
    input wire logic readStrobeN,
    input wire logic wpN,
    input wire logic [7:0] dqOut,
    input wire logic busy,
    // Answer lines.
    output logic [7:0] dqIn,
    output logic readyBusyN
);
    // Bytes one to three are arbitrary; four and five carry the feature codes.
    localparam logic [39:0] IDS = 40'h0c_62_33_22_11;
    logic [7:0] cmd = 8'hff;
    logic [2:0] idx = 3'h0;
    logic [7:0] val;
    // each new command replaces the mode
    always @(posedge weN) begin
        if (!ceN && cle) begin
            cmd <= dqOut;
            idx <= 3'h0;
        end
    end
    always @(posedge readStrobeN) idx <= idx + 3'h1;
    // pass/fail held at pass, protect level live
    always_comb begin
        val = {wpN, !busy, !busy, 5'h00};
        if (cmd == 8'h90) val = IDS[idx*8 +: 8];
    end
    // A released port shows the inverse so a stale byte is never mistaken for data.
    assign dqIn = (!ceN && !readStrobeN) ? val : ~val;
    assign readyBusyN = !busy;
endmodule

// [testbench.sv]
// Self-checking bench: status, feature and refusal sequences through the host.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdv;
    logic avs_waitrequest, ceN, cle, ale, weN, readStrobeN, wpN, dqOe, readyBusyN;
    logic [7:0] dqOut, dqIn;
    logic busy = 1'b1;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 clk_sys = ~clk_sys;
    nsc_host dut (.*);
    nsc_nand_model nand_dev (.*);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer; values read here are those sampled at the edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Order an operation, then poll until the sequencer is idle.
    task automatic cmd(input logic [15:0] c);
        bus(1'b1, 5'h00, {16'h0, c});
        repeat (100) begin
            bus(1'b0, 5'h04, 32'h0);
            if (rdv[0] === 1'b0) break;
        end
        check(rdv[0], 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(ceN, 1'b1);
        cmd(16'h0005);
        check(rdv[2:1], 2'b10);
        cmd(16'h0000);
        check(rdv[31:24], 8'h00);
        busy <= 1'b0;
        bus(1'b1, 5'h04, 32'h4);
        bus(1'b1, 5'h10, 32'h1);
        cmd(16'h0000);
        check(rdv[31:24], 8'he0);
        check(rdv[2:1], 2'b01);
        cmd(16'h4205);
        check(rdv[2], 1'b1);
        cmd(16'h0003);
        bus(1'b0, 5'h08, 32'h0);
        check(rdv, 32'h62332211);
        bus(1'b0, 5'h0c, 32'h0);
        check(rdv[14:0], 15'h7a0c);
        bus(1'b1, 5'h04, 32'h4);
        cmd(16'h8005);
        cmd(16'h9005);
        check(rdv[2], 1'b1);
        bus(1'b1, 5'h04, 32'h4);
        cmd(16'hff05);
        check(rdv[2], 1'b0);
        bus(1'b1, 5'h10, 32'h0);
        cmd(16'h0000);
        check(rdv[31:24], 8'h60);
        bus(1'b1, 5'h10, 32'h1);
        cmd(16'h0007);
        check(rdv[31:24], 8'he0);
        cmd(16'h0004);
        check(rdv[7], 1'b0);
        cmd(16'h0004);
        check(rdv[2], 1'b1);
        bus(1'b1, 5'h04, 32'h4);
        cmd(16'h8005);
        check(rdv[2], 1'b1);
        bus(1'b1, 5'h04, 32'h4);
        bus(1'b1, 5'h14, 32'h1);
        cmd(16'h8005);
        check(rdv[2], 1'b0);
        cmd(16'h1505);
        cmd(16'h0000);
        check(rdv[6], 1'b1);
        check(rdv[5], 1'b1);
        check(rdv[4], 1'b1);
        cmd(16'hff05);
        check(rdv[3], 1'b1);
        bus(1'b1, 5'h10, 32'h0);
        cmd(16'h0001);
        check(rdv[31:24], 8'h60);
        check(rdv[4], 1'b0);
        cmd(16'h0006);
        cmd(16'h5a08);
        check(rdv[2], 1'b0);
        bus(1'b0, 5'h00, 32'h0);
        check(rdv[15:8], 8'h71);
        cmd(16'h0009);
        check(rdv[2], 1'b1);
        bus(1'b0, 5'h1c, 32'h0);
        check(rdv, 32'h0);
        report_and_stop();
    end
endmodule
